// ### rtl/sdm_pkg.sv
/*
  shared constants and carriers of the synchronous dram module command side:
  command codes, mode word fields, register offsets and the presence-detect
  slave settings. assumes one system clock and an AHB-Lite register master.
*/
package sdm_pkg;

  // command codes as {row strobe, column strobe, write enable}, all active low
  localparam logic [2:0] CMD_LMR   = 3'h0;
  localparam logic [2:0] CMD_REF   = 3'h1;
  localparam logic [2:0] CMD_PRE   = 3'h2;
  localparam logic [2:0] CMD_ACT   = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ  = 3'h5;
  localparam logic [2:0] CMD_BT    = 3'h6;

  // mode word fields
  localparam int         MODE_W      = 12;
  localparam int         BL_LSB      = 0;
  localparam int         BT_BIT      = 3;
  localparam int         CL_LSB      = 4;
  localparam int         OPM_LSB     = 7;
  localparam int         WBP_BIT     = 9;
  localparam int         AP_BIT      = 10;
  localparam logic [2:0] BL_2        = 3'h1;
  localparam logic [2:0] BL_4        = 3'h2;
  localparam logic [2:0] BL_8        = 3'h3;
  localparam logic [2:0] BL_PAGE     = 3'h7;
  localparam logic [2:0] CL_3        = 3'h3;
  localparam logic [1:0] OPM_NORMAL  = 2'h0;

  // capacities and their address widths
  localparam logic [1:0]  CAP_64        = 2'h0;
  localparam logic [1:0]  CAP_256       = 2'h2;
  localparam logic [8:0]  COL_MASK_SML  = 9'h0FF;
  localparam logic [8:0]  COL_MASK_BIG  = 9'h1FF;
  localparam logic [12:0] ROW_MASK_SML  = 13'h0FFF;
  localparam logic [12:0] ROW_MASK_BIG  = 13'h1FFF;

  // register map, byte addresses
  localparam logic [7:0] CFG_OFF    = 8'h00;
  localparam logic [7:0] MODE_OFF   = 8'h04;
  localparam logic [7:0] STAT_OFF   = 8'h08;
  localparam logic [1:0] CFG_RST    = 2'h0;

  // presence-detect slave
  localparam logic [6:0] SPD_DEV_ADDR = 7'h50;
  localparam int         SPD_BYTES    = 256;

  // power-up wait of 100 us in 50 ns clocks
  localparam int         PWRUP_CLKS   = 2000;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] addr;
  } sdm_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  bank;
    logic [12:0] row;
    logic [8:0]  col;
    logic [63:0] wdata;
  } sdm_acc_t;

  typedef enum logic [4:0] {
    INIT_PWRUP  = 5'h01,
    INIT_PRECHD = 5'h02,
    INIT_REF1   = 5'h04,
    INIT_REF2   = 5'h08,
    INIT_READY  = 5'h10
  } sdm_init_t;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'h01,
    I2C_ADDR = 5'h02,
    I2C_WORD = 5'h04,
    I2C_WDAT = 5'h08,
    I2C_RDAT = 5'h10
  } sdm_i2c_t;

endpackage : sdm_pkg

// ### rtl/sdm_device.sv
/*
  command side of a four-bank synchronous dram module: bank/row tracking,
  burst column generation, read latency, mode word, presence-detect store on
  a serial two-wire slave, and an AHB-Lite register slave.
  assumes all inputs synchronous to clk_sys and an external array that answers
  acc with mem_rdata in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module sdm_device (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // command pins and data bus
  input  wire sdm_pkg::sdm_cmd_t cmd,
  input  wire logic [63:0]      dq_in,
  output logic      [63:0]      dq_out,
  output logic                  dq_oe,
  // array side
  output sdm_pkg::sdm_acc_t     acc,
  input  wire logic [63:0]      mem_rdata,
  // presence-detect two-wire pins
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic      [31:0]      hrdata,
  output logic                  hresp
);

  typedef struct packed {
    logic [1:0]                       cap;
    logic [sdm_pkg::MODE_W-1:0]       mode;
    sdm_pkg::sdm_init_t               init;
    logic [3:0]                       bank_open;
    logic [3:0][12:0]                 row;
    logic                             b_act;
    logic                             b_wr;
    logic                             b_il;
    logic                             b_ap;
    logic                             b_full;
    logic [1:0]                       b_bank;
    logic [8:0]                       b_start;
    logic [8:0]                       b_cnt;
    logic [8:0]                       b_mask;
    sdm_pkg::sdm_acc_t                acc;
    logic                             p1_v;
    logic [63:0]                      p1_d;
    logic [63:0]                      dq;
    logic                             dq_oe;
    logic                             ahb_wr;
    logic [7:0]                       ahb_a;
    logic [31:0]                      hrdata;
    logic                             hreadyout;
    logic                             hresp;
    logic                             scl_p;
    logic                             sda_p;
    sdm_pkg::sdm_i2c_t                i2c;
    logic [3:0]                       bits;
    logic [7:0]                       sh;
    logic [7:0]                       ptr;
    logic                             sda_oe;
    logic                             sda_o;
    logic [sdm_pkg::SPD_BYTES-1:0][7:0] presence_detect_store;
  } sdm_state_t;

  sdm_state_t s_q;
  sdm_state_t s_d;

  // block mask for a length code; page mask for full page
  function automatic logic [8:0] blk_mask(input logic [2:0] code, input logic [8:0] page);
    case (code)
      sdm_pkg::BL_2:    return 9'h001;
      sdm_pkg::BL_4:    return 9'h003;
      sdm_pkg::BL_8:    return 9'h007;
      sdm_pkg::BL_PAGE: return page;
      default:          return 9'h000;
    endcase
  endfunction : blk_mask

  // column of beat cnt inside the block selected by start
  function automatic logic [8:0] col_of(input logic [8:0] start, input logic [8:0] cnt,
                                        input logic [8:0] mask, input logic il);
    logic [8:0] off;
    off = il ? ((start ^ cnt) & mask) : (9'(start + cnt) & mask);
    return (start & ~mask) | off;
  endfunction : col_of

  logic        sel, is_rd, is_wr, rw_go, bt_go, pre_go, act_go, lmr_go, ref_go;
  logic        wr_single, new_full, b_end, rd_beat, lat3;
  logic        rise, fall, i2c_start, i2c_stop;
  logic [2:0]  op;
  logic [8:0]  col_mask, new_mask, col_next;
  logic [12:0] row_mask;

  assign sel      = !cmd.cs_n;
  assign op       = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign is_rd    = sel && op == sdm_pkg::CMD_READ;
  assign is_wr    = sel && op == sdm_pkg::CMD_WRITE;
  assign rw_go    = (is_rd || is_wr) && s_q.init == sdm_pkg::INIT_READY
                    && s_q.mode[sdm_pkg::OPM_LSB +: 2] == sdm_pkg::OPM_NORMAL
                    && s_q.bank_open[cmd.ba];
  assign bt_go    = sel && op == sdm_pkg::CMD_BT;
  assign pre_go   = sel && op == sdm_pkg::CMD_PRE;
  assign act_go   = sel && op == sdm_pkg::CMD_ACT;
  assign lmr_go   = sel && op == sdm_pkg::CMD_LMR;
  assign ref_go   = sel && op == sdm_pkg::CMD_REF;
  assign col_mask = (s_q.cap == sdm_pkg::CAP_64) ? sdm_pkg::COL_MASK_SML
                                                 : sdm_pkg::COL_MASK_BIG;
  assign row_mask = (s_q.cap == sdm_pkg::CAP_256) ? sdm_pkg::ROW_MASK_BIG
                                                  : sdm_pkg::ROW_MASK_SML;
  assign wr_single = is_wr && s_q.mode[sdm_pkg::WBP_BIT];
  assign new_mask = wr_single ? 9'h000
                              : blk_mask(s_q.mode[sdm_pkg::BL_LSB +: 3], col_mask);
  assign new_full = !wr_single && s_q.mode[sdm_pkg::BL_LSB +: 3] == sdm_pkg::BL_PAGE;
  assign col_next = col_of(s_q.b_start, s_q.b_cnt, s_q.b_mask, s_q.b_il);
  assign b_end    = s_q.b_act && !s_q.b_full && s_q.b_cnt == s_q.b_mask;
  assign rd_beat  = s_q.acc.valid && !s_q.acc.write;
  assign lat3     = s_q.mode[sdm_pkg::CL_LSB +: 3] == sdm_pkg::CL_3;
  assign rise     = scl_in && !s_q.scl_p;
  assign fall     = !scl_in && s_q.scl_p;
  assign i2c_start = scl_in && s_q.scl_p && s_q.sda_p && !sda_in;
  assign i2c_stop  = scl_in && s_q.scl_p && !s_q.sda_p && sda_in;

  always_comb begin
    s_d = s_q;
    s_d.acc.valid = 1'b0;
    // bank state; a precharge to another bank leaves the running burst alone
    if (act_go) begin
      s_d.bank_open[cmd.ba] = 1'b1;
      s_d.row[cmd.ba]       = cmd.addr & row_mask;
    end
    if (pre_go) begin
      if (cmd.addr[sdm_pkg::AP_BIT]) begin
        s_d.bank_open = 4'h0;
      end else begin
        s_d.bank_open[cmd.ba] = 1'b0;
      end
    end
    // burst engine: an accepted column command (device ready, normal operating mode, bank open) always wins over the running burst
    if (rw_go) begin
      s_d.acc     = {1'b1, is_wr, cmd.ba, s_q.row[cmd.ba], cmd.addr[8:0] & col_mask, dq_in};
      s_d.b_act   = new_mask != 9'h000 || new_full;
      s_d.b_wr    = is_wr;
      s_d.b_bank  = cmd.ba;
      s_d.b_start = cmd.addr[8:0] & col_mask;
      s_d.b_cnt   = 9'h001;
      s_d.b_mask  = new_mask;
      s_d.b_full  = new_full;
      s_d.b_il    = s_q.mode[sdm_pkg::BT_BIT] && !new_full;
      s_d.b_ap    = cmd.addr[sdm_pkg::AP_BIT];
      if (!s_d.b_act && cmd.addr[sdm_pkg::AP_BIT]) begin
        s_d.bank_open[cmd.ba] = 1'b0;
      end
    end else if (bt_go) begin
      s_d.b_act = 1'b0;
    end else if (s_q.b_act) begin
      s_d.acc   = {1'b1, s_q.b_wr, s_q.b_bank, s_q.row[s_q.b_bank], col_next, dq_in};
      s_d.b_cnt = 9'(s_q.b_cnt + 9'h001);
      if (b_end) begin
        s_d.b_act = 1'b0;
        if (s_q.b_ap) begin
          s_d.bank_open[s_q.b_bank] = 1'b0;
        end
      end
    end
    // power-up progress, tracked for status and to gate accesses
    case (s_q.init)
      sdm_pkg::INIT_PWRUP:  if (pre_go && cmd.addr[sdm_pkg::AP_BIT]) s_d.init = sdm_pkg::INIT_PRECHD;
      sdm_pkg::INIT_PRECHD: if (ref_go) s_d.init = sdm_pkg::INIT_REF1;
      sdm_pkg::INIT_REF1:   if (ref_go) s_d.init = sdm_pkg::INIT_REF2;
      sdm_pkg::INIT_REF2:   if (lmr_go) s_d.init = sdm_pkg::INIT_READY;
      sdm_pkg::INIT_READY:  s_d.init = sdm_pkg::INIT_READY;
      default:              s_d.init = sdm_pkg::INIT_PWRUP;
    endcase
    if (lmr_go) begin
      s_d.mode = cmd.addr[sdm_pkg::MODE_W-1:0];
    end
    // read data pipe: two or three clocks from command to valid data
    s_d.p1_v  = rd_beat;
    s_d.p1_d  = mem_rdata;
    s_d.dq_oe = lat3 ? s_q.p1_v : rd_beat;
    s_d.dq    = lat3 ? s_q.p1_d : mem_rdata;
    // register slave, zero wait states
    s_d.ahb_wr = 1'b0;
    if (s_q.ahb_wr && s_q.ahb_a == sdm_pkg::CFG_OFF) begin
      s_d.cap = hwdata[1:0];
    end
    if (hsel && htrans[1] && hready) begin
      s_d.ahb_wr = hwrite;
      s_d.ahb_a  = haddr[7:0];
      s_d.hrdata = 32'h0000_0000;
      if (!hwrite && haddr[31:8] == 24'h00_0000) begin
        case (haddr[7:0])
          sdm_pkg::CFG_OFF:  s_d.hrdata = {30'h0000_0000, s_q.cap};
          sdm_pkg::MODE_OFF: s_d.hrdata = {20'h0_0000, s_q.mode};
          sdm_pkg::STAT_OFF: s_d.hrdata = {22'h00_0000, s_q.init, s_q.b_act, s_q.bank_open};
          default:           s_d.hrdata = 32'h0000_0000;
        endcase
      end
      if (haddr[31:8] != 24'h00_0000) begin
        s_d.ahb_wr = 1'b0;
      end
    end
    // presence-detect slave; sda sampled around scl edges
    s_d.scl_p = scl_in;
    s_d.sda_p = sda_in;
    if (i2c_start) begin
      s_d.i2c    = sdm_pkg::I2C_ADDR;
      s_d.bits   = 4'h0;
      s_d.sda_oe = 1'b0;
    end else if (i2c_stop) begin
      s_d.i2c    = sdm_pkg::I2C_IDLE;
      s_d.sda_oe = 1'b0;
    end else if (s_q.i2c != sdm_pkg::I2C_IDLE) begin
      if (rise) begin
        if (s_q.i2c == sdm_pkg::I2C_RDAT) begin
          if (s_q.bits == 4'h8) begin
            if (sda_in) begin
              s_d.i2c = sdm_pkg::I2C_IDLE;
            end else begin
              s_d.bits = 4'h0;
              s_d.ptr  = 8'(s_q.ptr + 8'h01);
            end
          end else if (s_q.bits < 4'h8) begin
            s_d.bits = 4'(s_q.bits + 4'h1);
          end
        end else if (s_q.bits < 4'h8) begin
          s_d.sh   = {s_q.sh[6:0], sda_in};
          s_d.bits = 4'(s_q.bits + 4'h1);
        end
      end
      if (fall) begin
        if (s_q.bits == 4'h9) begin
          s_d.bits   = 4'h0;
          s_d.sda_oe = (s_q.i2c == sdm_pkg::I2C_RDAT) && !s_q.presence_detect_store[s_q.ptr][7];
        end else if (s_q.i2c == sdm_pkg::I2C_RDAT) begin
          s_d.sda_oe = (s_q.bits < 4'h8) && !s_q.presence_detect_store[s_q.ptr][3'(4'h7 - s_q.bits)];
        end else if (s_q.bits == 4'h8) begin
          s_d.sda_oe = 1'b1;
          s_d.bits   = 4'h9;
          case (s_q.i2c)
            sdm_pkg::I2C_ADDR: begin
              if (s_q.sh[7:1] == sdm_pkg::SPD_DEV_ADDR) begin
                s_d.i2c = s_q.sh[0] ? sdm_pkg::I2C_RDAT : sdm_pkg::I2C_WORD;
              end else begin
                s_d.i2c    = sdm_pkg::I2C_IDLE;
                s_d.sda_oe = 1'b0;
              end
            end
            sdm_pkg::I2C_WORD: begin
              s_d.ptr = s_q.sh;
              s_d.i2c = sdm_pkg::I2C_WDAT;
            end
            sdm_pkg::I2C_WDAT: begin
              s_d.presence_detect_store[s_q.ptr] = s_q.sh;
              s_d.ptr          = 8'(s_q.ptr + 8'h01);
            end
            default: s_d.i2c = sdm_pkg::I2C_IDLE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.cap       <= sdm_pkg::CFG_RST;
      s_q.init      <= sdm_pkg::INIT_PWRUP;
      s_q.i2c       <= sdm_pkg::I2C_IDLE;
      s_q.hreadyout <= 1'b1;
      s_q.scl_p     <= 1'b1;
      s_q.sda_p     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign dq_out    = s_q.dq;
  assign dq_oe     = s_q.dq_oe;
  assign acc       = s_q.acc;
  assign sda_out   = s_q.sda_o;
  assign sda_oe    = s_q.sda_oe;
  assign hreadyout = s_q.hreadyout;
  assign hrdata    = s_q.hrdata;
  assign hresp     = s_q.hresp;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_rd_beat: assert property (rw_go && is_rd |=> rd_beat
    && s_q.acc.col == ($past(cmd.addr[8:0]) & $past(col_mask)))
    else $error("read command did not issue its first column");
  chk_lat_three: assert property (rd_beat && !$past(rd_beat) && lat3 && !lmr_go
    |=> !dq_oe ##1 dq_oe)
    else $error("latency three data not driven two edges after the beat");
  chk_term_stop: assert property (bt_go && !rw_go |=> !s_q.b_act && !s_q.acc.valid)
    else $error("burst terminate did not stop the burst");
  chk_ap_close: assert property (b_end && s_q.b_ap && !rw_go && !bt_go && !act_go
    |=> !s_q.bank_open[$past(s_q.b_bank)])
    else $error("auto precharge left the row open");
  chk_block_wrap: assert property (s_q.b_act && !rw_go && !bt_go
    |=> ((s_q.acc.col ^ $past(s_q.b_start)) & ~$past(s_q.b_mask)) == 9'h000)
    else $error("burst column left its block");
  chk_mode_load: assert property (lmr_go |=> s_q.mode == $past(cmd.addr[11:0]))
    else $error("mode word not loaded");
  chk_mode_hold: assert property (!lmr_go |=> $stable(s_q.mode))
    else $error("mode word changed without load");
  chk_pre_other: assert property (s_q.b_act && !b_end && pre_go && !cmd.addr[sdm_pkg::AP_BIT]
    && cmd.ba != s_q.b_bank && !bt_go && !rw_go |=> s_q.b_act && s_q.acc.valid)
    else $error("precharge of another bank disturbed the burst");
  chk_spd_release: assert property (i2c_start |=> !sda_oe && s_q.bits == 4'h0)
    else $error("start condition did not reset the serial slave");

endmodule : sdm_device

`default_nettype wire

// ### bench/sdm_ctrl_model.sv
/*
  memory controller model: drives command pins and write data at the clock
  edge, runs the power-up sequence and mode loads.
  assumes the device samples cmd and dq_in at every rising edge of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module sdm_ctrl_model (
  // clock
  input  wire logic         clk_sys,
  // command pins and write data
  output sdm_pkg::sdm_cmd_t cmd,
  output logic [63:0]       dq_in
);
  initial begin
    cmd = {1'b1, 3'h7, 2'h0, 13'h0};
    dq_in = 64'h0;
  end

  task issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
             input logic [63:0] d);
    @(posedge clk_sys);
    cmd <= {1'b0, c, b, a};
    // data only stands with a write; otherwise the bus keeps toggling
    dq_in <= (c == sdm_pkg::CMD_WRITE) ? d : ~dq_in;
  endtask : issue

  task idle(input int n);
    repeat (n) issue(3'h7, 2'h0, 13'h0, 64'h0);
  endtask : idle

  task load(input logic [11:0] m);
    for (int i = 0; i < 4; i++) issue(sdm_pkg::CMD_PRE, i[1:0], 13'h0, 64'h0);
    issue(sdm_pkg::CMD_LMR, 2'h0, {1'b0, m}, 64'h0);
    idle(2);
  endtask : load

  task power_up(input logic [11:0] m);
    // hold the last command through 100 us (2000 clocks), then at least one nop
    repeat (sdm_pkg::PWRUP_CLKS + 1) @(posedge clk_sys);
    idle(1);
    issue(sdm_pkg::CMD_PRE, 2'h0, 13'h0400, 64'h0);
    issue(sdm_pkg::CMD_REF, 2'h0, 13'h0, 64'h0);
    issue(sdm_pkg::CMD_REF, 2'h0, 13'h0, 64'h0);
    issue(sdm_pkg::CMD_LMR, 2'h0, {1'b0, m}, 64'h0);
    idle(2);
  endtask : power_up
endmodule : sdm_ctrl_model

`default_nettype wire

// ### bench/sdm_module_burst_access_test.sv
/*
  testbench of the dram module command side: register reads over AHB-Lite,
  command sequences through the controller model, beat order and latency.
  assumes a single 20 MHz clock; the array answers with its column number.
*/
`timescale 1ns/1ps
`default_nettype none

module sdm_module_burst_access_test;
  logic clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp, dq_oe, sda_out, sda_oe;
  logic [1:0]  htrans, cap;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [63:0] dq_in, dq_out, mem_rdata, wd_seen;
  logic [12:0] row_seen;
  logic        wr_seen;
  logic [8:0]  q[$];
  logic [8:0]  r9;
  logic        scl_m, sda_m, sda_line;
  int          errors, checks_done;
  sdm_pkg::sdm_cmd_t cmd;
  sdm_pkg::sdm_acc_t acc;

  assign mem_rdata = {55'h0, acc.col};
  assign hready = hreadyout;
  // open-drain data line: either side may pull it low
  assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);

  sdm_device sdm_device_inst (.clk_sys, .rst_n, .cmd, .dq_in, .dq_out, .dq_oe, .acc,
    .mem_rdata, .scl_in(scl_m), .sda_in(sda_line), .sda_out, .sda_oe, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp);
  sdm_ctrl_model sdm_ctrl_model_inst (.clk_sys, .cmd, .dq_in);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // beat monitor: first beat's row and data kept
  always @(posedge clk_sys) if (acc.valid === 1'b1) begin
    if (q.size() == 0) begin
      row_seen <= acc.row;
      wr_seen <= acc.write;
      wd_seen <= acc.wdata;
    end
    q.push_back(acc.col);
  end

  task end_of_test;
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task reg_acc(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask : reg_acc

  task rd_chk(input logic [31:0] a, input logic [31:0] e);
    reg_acc(a, 1'b0, 32'h0);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd_chk

  task iss(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
    sdm_ctrl_model_inst.issue(c, b, a, 64'h0);
  endtask : iss

  function automatic logic [8:0] cmask;
    return cap == 2'h0 ? sdm_pkg::COL_MASK_SML : sdm_pkg::COL_MASK_BIG;
  endfunction : cmask

  function automatic logic [8:0] ecol(input logic [2:0] bl, input logic il,
                                      input logic [8:0] st, input int k);
    logic [8:0] m, s, o;
    s = st & cmask();
    case (bl)
      3'h1: m = 9'h001;
      3'h2: m = 9'h003;
      3'h3: m = 9'h007;
      3'h7: m = cmask();
      default: m = 9'h000;
    endcase
    o = (il && bl != 3'h7) ? (s ^ k[8:0]) : (s + k[8:0]);
    return (s & ~m) | (o & m);
  endfunction : ecol

  task run_burst(input logic [2:0] bl, input logic il, input logic [2:0] cl,
                 input logic [8:0] st, input int n);
    int j;
    logic [11:0] m;
    m = {5'h0, cl, il, bl};
    sdm_ctrl_model_inst.load(m);
    iss(sdm_pkg::CMD_ACT, 2'h1, 13'h1ABC);
    q.delete();
    iss(sdm_pkg::CMD_READ, 2'h1, {4'h0, st});
    iss(3'h7, 2'h0, 13'h0);
    j = 1;
    #1;
    while (dq_oe !== 1'b1 && j < 8) begin
      @(posedge clk_sys);
      #1;
      j++;
    end
    chk(j, {29'h0, cl});
    chk(dq_out[31:0], {23'h0, ecol(bl, il, st, 0)});
    sdm_ctrl_model_inst.idle(10);
    chk(q.size(), n);
    for (int i = 0; i < n; i++) chk({23'h0, q[i]}, {23'h0, ecol(bl, il, st, i)});
    chk({19'h0, row_seen}, {19'h0, cap == 2'h2 ? 13'h1ABC : 13'h0ABC});
    rd_chk(sdm_pkg::MODE_OFF, {20'h0, m});
  endtask : run_burst

  task run_page(input logic il, input logic [8:0] st);
    sdm_ctrl_model_inst.load({5'h0, 3'h2, il, 3'h7});
    iss(sdm_pkg::CMD_ACT, 2'h1, 13'h0);
    q.delete();
    iss(sdm_pkg::CMD_READ, 2'h1, {4'h0, st});
    sdm_ctrl_model_inst.idle(2);
    iss(sdm_pkg::CMD_BT, 2'h0, 13'h0);
    sdm_ctrl_model_inst.idle(10);
    chk(q.size(), 3);
    for (int i = 0; i < 3; i++) chk({23'h0, q[i]}, {23'h0, ecol(3'h7, il, st, i)});
  endtask : run_page

  // two-wire master: every phase lasts four clocks, except the clock-high phase of a bit in i2c_byte, which lasts six
  task i2c_ph(input logic c, input logic d);
    repeat (4) @(posedge clk_sys);
    scl_m <= c;
    sda_m <= d;
  endtask : i2c_ph

  task i2c_frame(input logic stop);
    if (stop) begin
      i2c_ph(1'b0, 1'b0);
      i2c_ph(1'b1, 1'b0);
      i2c_ph(1'b1, 1'b1);
    end else begin
      i2c_ph(1'b0, 1'b1);
      i2c_ph(1'b1, 1'b1);
      i2c_ph(1'b1, 1'b0);
      i2c_ph(1'b0, 1'b0);
    end
  endtask : i2c_frame

  // eight data bits and the ninth; r is the line seen while the clock is high
  task i2c_byte(input logic [8:0] b, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      i2c_ph(1'b0, b[i]);
      i2c_ph(1'b1, b[i]);
      repeat (2) @(posedge clk_sys);
      r[i] = sda_line;
      i2c_ph(1'b0, b[i]);
    end
  endtask : i2c_byte

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end

  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, cap} = '0;
    hsize = 3'h2;
    {scl_m, sda_m} = 2'h3;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    hsel <= 1'b1;
    rd_chk(sdm_pkg::STAT_OFF, 32'h20);
    rd_chk(32'hC, 32'h0);
    reg_acc(sdm_pkg::MODE_OFF, 1'b1, 32'hFFF);
    rd_chk(sdm_pkg::MODE_OFF, 32'h0);
    iss(sdm_pkg::CMD_ACT, 2'h0, 13'h0);
    q.delete();
    iss(sdm_pkg::CMD_READ, 2'h0, 13'h0);
    sdm_ctrl_model_inst.idle(6);
    chk(q.size(), 0);
    sdm_ctrl_model_inst.power_up(12'h022);
    rd_chk(sdm_pkg::STAT_OFF, 32'h200);
    rd_chk(sdm_pkg::MODE_OFF, 32'h022);
    i2c_frame(1'b0);
    i2c_byte({8'hA0, 1'b1}, r9);
    chk({23'h0, r9}, {23'h0, 8'hA0, 1'b0});
    i2c_byte({8'h85, 1'b1}, r9);
    chk({23'h0, r9}, {23'h0, 8'h85, 1'b0});
    i2c_byte({8'hC3, 1'b1}, r9);
    chk({23'h0, r9}, {23'h0, 8'hC3, 1'b0});
    i2c_frame(1'b1);
    i2c_frame(1'b0);
    i2c_byte({8'hA0, 1'b1}, r9);
    i2c_byte({8'h85, 1'b1}, r9);
    i2c_frame(1'b0);
    i2c_byte({8'hA1, 1'b1}, r9);
    chk({23'h0, r9}, {23'h0, 8'hA1, 1'b0});
    i2c_byte(9'h1FF, r9);
    chk({23'h0, r9}, {23'h0, 8'hC3, 1'b1});
    i2c_frame(1'b1);
    for (int k = 0; k < 2; k++) begin
      cap = k ? 2'h2 : 2'h0;
      reg_acc(sdm_pkg::CFG_OFF, 1'b1, {30'h0, cap});
      rd_chk(sdm_pkg::CFG_OFF, {30'h0, cap});
      run_burst(3'h0, 1'b0, 3'h2, 9'h1F3, 1);
      run_page(1'b0, cmask());
    end
    run_burst(3'h1, 1'b0, 3'h2, 9'h001, 2);
    run_burst(3'h1, 1'b1, 3'h3, 9'h000, 2);
    run_burst(3'h2, 1'b0, 3'h2, 9'h005, 4);
    run_burst(3'h2, 1'b1, 3'h3, 9'h005, 4);
    run_burst(3'h3, 1'b0, 3'h2, 9'h006, 8);
    run_burst(3'h3, 1'b1, 3'h2, 9'h005, 8);
    run_burst(3'h3, 1'b1, 3'h3, 9'h10B, 8);
    run_burst(3'h4, 1'b0, 3'h2, 9'h007, 1);
    run_page(1'b1, 9'h1FE);
    for (int w = 0; w < 2; w++) begin
      sdm_ctrl_model_inst.load({2'h0, w[0], 2'h0, 3'h2, 1'b0, 3'h2});
      iss(sdm_pkg::CMD_ACT, 2'h1, 13'h0);
      q.delete();
      sdm_ctrl_model_inst.issue(sdm_pkg::CMD_WRITE, 2'h1, 13'h0010, 64'h0123456789ABCDEF);
      sdm_ctrl_model_inst.idle(10);
      chk(q.size(), w ? 1 : 4);
      chk({31'h0, wr_seen}, 32'h1);
      chk(wd_seen[31:0], 32'h89ABCDEF);
    end
    sdm_ctrl_model_inst.load(12'h0A2);
    iss(sdm_pkg::CMD_ACT, 2'h1, 13'h0);
    q.delete();
    iss(sdm_pkg::CMD_READ, 2'h1, 13'h0);
    sdm_ctrl_model_inst.idle(6);
    chk(q.size(), 0);
    sdm_ctrl_model_inst.load(12'h021);
    iss(sdm_pkg::CMD_ACT, 2'h2, 13'h0);
    sdm_ctrl_model_inst.idle(2);
    rd_chk(sdm_pkg::STAT_OFF, 32'h204);
    q.delete();
    iss(sdm_pkg::CMD_READ, 2'h2, 13'h0403);
    sdm_ctrl_model_inst.idle(8);
    chk({23'h0, q[1]}, 32'h2);
    rd_chk(sdm_pkg::STAT_OFF, 32'h200);
    sdm_ctrl_model_inst.load(12'h023);
    iss(sdm_pkg::CMD_ACT, 2'h0, 13'h0);
    iss(sdm_pkg::CMD_ACT, 2'h1, 13'h0);
    q.delete();
    iss(sdm_pkg::CMD_READ, 2'h0, 13'h0);
    iss(sdm_pkg::CMD_PRE, 2'h1, 13'h0);
    sdm_ctrl_model_inst.idle(12);
    chk(q.size(), 8);
    rd_chk(sdm_pkg::STAT_OFF, 32'h201);
    sdm_ctrl_model_inst.load(12'h022);
    iss(sdm_pkg::CMD_ACT, 2'h0, 13'h0);
    q.delete();
    iss(sdm_pkg::CMD_READ, 2'h0, 13'h0008);
    iss(sdm_pkg::CMD_READ, 2'h0, 13'h0010);
    sdm_ctrl_model_inst.idle(10);
    chk(q.size(), 5);
    chk({23'h0, q[1]}, 32'h10);
    chk({23'h0, q[4]}, 32'h13);
    end_of_test();
  end
endmodule : sdm_module_burst_access_test

`default_nettype wire
